// ===== src/uad_pkg.sv
// constants, tables and carrier types for the alternate-setting descriptor server
`default_nettype none
package uad_pkg;
	// descriptor framing
	localparam logic [7:0] UAD_EP_DESC_LEN = 8'h07;
	localparam logic [7:0] UAD_EP_DESC_TYPE = 8'h05;
	localparam logic [7:0] UAD_IF_DESC_LEN = 8'h09;
	localparam logic [7:0] UAD_IF_DESC_TYPE = 8'h04;
	localparam logic [7:0] UAD_IF_NUMBER = 8'h00;
	localparam logic [7:0] UAD_VENDOR_CODE = 8'hff;
	localparam logic [7:0] UAD_NO_STRING = 8'h00;
	localparam logic [7:0] UAD_ALT2_NUM_EP = 8'h06;
	// alternate settings
	localparam logic [7:0] UAD_ALT_DEFAULT = 8'h00;
	localparam logic [7:0] UAD_ALT_BULK = 8'h01;
	localparam logic [7:0] UAD_ALT_MIXED = 8'h02;
	localparam logic [7:0] UAD_ALT_MAX = 8'h03;
	// endpoint attribute fields
	localparam logic [1:0] UAD_XFER_BULK = 2'h2;
	localparam logic [1:0] UAD_XFER_INT = 2'h3;
	localparam logic UAD_DIR_IN = 1'b1;
	localparam logic UAD_DIR_OUT = 1'b0;
	localparam logic [15:0] UAD_PKT_512 = 16'h0200;
	localparam logic [15:0] UAD_PKT_64 = 16'h0040;
	localparam logic [7:0] UAD_IVAL_BULK = 8'h00;
	localparam logic [7:0] UAD_IVAL_INT_1MS = 8'h01;
	// endpoint descriptor byte offsets
	localparam logic [3:0] UAD_OFS_LEN = 4'h0;
	localparam logic [3:0] UAD_OFS_TYPE = 4'h1;
	localparam logic [3:0] UAD_OFS_ADDR = 4'h2;
	localparam logic [3:0] UAD_OFS_ATTR = 4'h3;
	localparam logic [3:0] UAD_OFS_PKT_LO = 4'h4;
	localparam logic [3:0] UAD_OFS_PKT_HI = 4'h5;
	localparam logic [3:0] UAD_OFS_IVAL = 4'h6;
	// interface descriptor byte offsets
	localparam logic [3:0] UAD_OFS_IF_NUM = 4'h2;
	localparam logic [3:0] UAD_OFS_IF_ALT = 4'h3;
	localparam logic [3:0] UAD_OFS_IF_NEP = 4'h4;
	localparam logic [3:0] UAD_OFS_IF_CLASS = 4'h5;
	localparam logic [3:0] UAD_OFS_IF_SUB = 4'h6;
	localparam logic [3:0] UAD_OFS_IF_PROTO = 4'h7;
	localparam logic [3:0] UAD_OFS_IF_STR = 4'h8;
	// rom entry map
	localparam logic [3:0] UAD_ENT_ALT2_IF = 4'h0;
	localparam logic [3:0] UAD_ENT_ALT1_EP0 = 4'h1;
	localparam logic [3:0] UAD_ENT_ALT2_EP0 = 4'h5;
	localparam logic [3:0] UAD_ENT_COUNT = 4'hb;
	localparam int UAD_ALT1_EPS = 4;
	localparam int UAD_ALT2_EPS = 6;

	typedef struct packed {
		logic dir;
		logic [3:0] num;
		logic [1:0] xfer;
		logic [15:0] max_pkt;
		logic [7:0] interval;
	} uad_ep_type;

	typedef struct packed {
		logic is_endpoint;
		logic [2:0] ep_index;
		logic [15:0] max_len;
	} uad_req_type;

	typedef struct packed {
		logic [7:0] data;
		logic last;
	} uad_byte_type;

	typedef enum logic [2:0] {
		UAD_ST_IDLE = 3'b001,
		UAD_ST_FETCH = 3'b010,
		UAD_ST_SEND = 3'b100
	} uad_state_type;

	localparam uad_ep_type UAD_ALT1_TABLE [0:3] = '{
		'{UAD_DIR_OUT, 4'h2, UAD_XFER_BULK, UAD_PKT_512, UAD_IVAL_BULK},
		'{UAD_DIR_OUT, 4'h4, UAD_XFER_BULK, UAD_PKT_512, UAD_IVAL_BULK},
		'{UAD_DIR_IN, 4'h6, UAD_XFER_BULK, UAD_PKT_512, UAD_IVAL_BULK},
		'{UAD_DIR_IN, 4'h8, UAD_XFER_BULK, UAD_PKT_512, UAD_IVAL_BULK}
	};

	localparam uad_ep_type UAD_ALT2_TABLE [0:5] = '{
		'{UAD_DIR_OUT, 4'h1, UAD_XFER_INT, UAD_PKT_64, UAD_IVAL_INT_1MS},
		'{UAD_DIR_IN, 4'h1, UAD_XFER_INT, UAD_PKT_64, UAD_IVAL_INT_1MS},
		'{UAD_DIR_OUT, 4'h2, UAD_XFER_INT, UAD_PKT_512, UAD_IVAL_INT_1MS},
		'{UAD_DIR_OUT, 4'h4, UAD_XFER_BULK, UAD_PKT_512, UAD_IVAL_BULK},
		'{UAD_DIR_IN, 4'h6, UAD_XFER_INT, UAD_PKT_512, UAD_IVAL_INT_1MS},
		'{UAD_DIR_IN, 4'h8, UAD_XFER_BULK, UAD_PKT_512, UAD_IVAL_BULK}
	};
endpackage
`default_nettype wire

// ===== src/uad_desc_rom.sv
// descriptor byte rom with registered read data
`timescale 1ns/1ps
`default_nettype none
module uad_desc_rom (
	// clock and reset
	input wire logic sys_clk_in,
	input wire logic rstn_in,
	// read port
	input wire logic [3:0] entry_in,
	input wire logic [3:0] offset_in,
	output logic [7:0] rd_data_out
);
	function automatic logic [7:0] ep_byte(input uad_pkg::uad_ep_type ep, input logic [3:0] ofs);
		logic [7:0] b;
		b = 8'h00;
		case (ofs)
			uad_pkg::UAD_OFS_LEN: b = uad_pkg::UAD_EP_DESC_LEN;
			uad_pkg::UAD_OFS_TYPE: b = uad_pkg::UAD_EP_DESC_TYPE;
			uad_pkg::UAD_OFS_ADDR: b = {ep.dir, 3'h0, ep.num};
			uad_pkg::UAD_OFS_ATTR: b = {6'h00, ep.xfer};
			uad_pkg::UAD_OFS_PKT_LO: b = ep.max_pkt[7:0];
			uad_pkg::UAD_OFS_PKT_HI: b = ep.max_pkt[15:8];
			uad_pkg::UAD_OFS_IVAL: b = ep.interval;
			default: b = 8'h00;
		endcase
		return b;
	endfunction

	function automatic logic [7:0] if_byte(input logic [3:0] ofs);
		logic [7:0] b;
		b = 8'h00;
		case (ofs)
			uad_pkg::UAD_OFS_LEN: b = uad_pkg::UAD_IF_DESC_LEN;
			uad_pkg::UAD_OFS_TYPE: b = uad_pkg::UAD_IF_DESC_TYPE;
			uad_pkg::UAD_OFS_IF_NUM: b = uad_pkg::UAD_IF_NUMBER;
			uad_pkg::UAD_OFS_IF_ALT: b = uad_pkg::UAD_ALT_MIXED;
			uad_pkg::UAD_OFS_IF_NEP: b = uad_pkg::UAD_ALT2_NUM_EP;
			uad_pkg::UAD_OFS_IF_CLASS: b = uad_pkg::UAD_VENDOR_CODE;
			uad_pkg::UAD_OFS_IF_SUB: b = uad_pkg::UAD_VENDOR_CODE;
			uad_pkg::UAD_OFS_IF_PROTO: b = uad_pkg::UAD_VENDOR_CODE;
			uad_pkg::UAD_OFS_IF_STR: b = uad_pkg::UAD_NO_STRING;
			default: b = 8'h00;
		endcase
		return b;
	endfunction

	logic [7:0] rom_byte;

	always_comb
	begin
		rom_byte = 8'h00;
		if (entry_in == uad_pkg::UAD_ENT_ALT2_IF)
			rom_byte = if_byte(offset_in);
		else if (entry_in < uad_pkg::UAD_ENT_ALT2_EP0)
			rom_byte = ep_byte(uad_pkg::UAD_ALT1_TABLE[2'(entry_in - uad_pkg::UAD_ENT_ALT1_EP0)],
				offset_in);
		else if (entry_in < uad_pkg::UAD_ENT_COUNT)
			// interrupt and bulk mix of the second setting
			rom_byte = ep_byte(uad_pkg::UAD_ALT2_TABLE[3'(entry_in - uad_pkg::UAD_ENT_ALT2_EP0)],
				offset_in);
	end

	always_ff @(posedge sys_clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
			rd_data_out <= 8'h00;
		else
			rd_data_out <= rom_byte;
	end
endmodule
`default_nettype wire

// ===== src/uad_descriptor_server.sv
// serves endpoint descriptors for the selected alternate setting when it is 1 or 2, and the interface descriptor of setting 2 only
`timescale 1ns/1ps
`default_nettype none
module uad_descriptor_server (
	// clock and reset
	input wire logic sys_clk_in,
	input wire logic rstn_in,
	// set-interface request from the control decoder
	input wire logic setif_valid_in,
	input wire logic [7:0] setif_alt_in,
	output logic setif_ready_out,
	output logic setif_stall_out,
	output logic [7:0] alt_setting_out,
	// get-descriptor request from the control decoder
	input wire logic desc_req_valid_in,
	input wire uad_pkg::uad_req_type desc_req_in,
	output logic desc_req_ready_out,
	output logic desc_stall_out,
	// descriptor byte stream toward the control data stage
	output logic desc_byte_valid_out,
	output uad_pkg::uad_byte_type desc_byte_out,
	input wire logic desc_byte_ready_in
);
	uad_pkg::uad_state_type state_r;
	uad_pkg::uad_state_type state_nxt;
	logic [7:0] alt_r;
	logic [3:0] entry_r;
	logic [3:0] offset_r;
	logic [7:0] remain_r;
	logic setif_stall_r;
	logic desc_stall_r;
	logic [7:0] rom_data;
	logic last_r;
	logic idle;
	logic fetching;
	logic sending;
	logic setif_take;
	logic req_take;
	logic req_ok;
	logic req_load;
	logic [4:0] req_map;
	logic [3:0] req_entry;
	logic [7:0] req_len;
	logic byte_take;

	// maps the selected setting and requested descriptor to a rom entry
	function automatic logic [4:0] entry_of(input logic [7:0] alt, input uad_pkg::uad_req_type rq);
		logic [4:0] r;
		r = 5'h00;
		if (alt == uad_pkg::UAD_ALT_MIXED)
		begin
			if (!rq.is_endpoint)
				r = {1'b1, uad_pkg::UAD_ENT_ALT2_IF};
			else if (int'(rq.ep_index) < uad_pkg::UAD_ALT2_EPS)
				r = {1'b1, 4'(uad_pkg::UAD_ENT_ALT2_EP0 + 4'(rq.ep_index))};
		end
		else if (alt == uad_pkg::UAD_ALT_BULK)
		begin
			if (rq.is_endpoint && int'(rq.ep_index) < uad_pkg::UAD_ALT1_EPS)
				r = {1'b1, 4'(uad_pkg::UAD_ENT_ALT1_EP0 + 4'(rq.ep_index))};
		end
		return r;
	endfunction

	// bytes to send: descriptor length cut to the host's requested length
	function automatic logic [7:0] len_of(input uad_pkg::uad_req_type rq);
		logic [7:0] full;
		full = rq.is_endpoint ? uad_pkg::UAD_EP_DESC_LEN : uad_pkg::UAD_IF_DESC_LEN;
		if (rq.max_len < 16'(full))
			return rq.max_len[7:0];
		return full;
	endfunction

	// only settings up to UAD_ALT_MAX (3) may be selected, one above the highest with descriptors
	function automatic logic alt_legal(input logic [7:0] alt);
		return alt <= uad_pkg::UAD_ALT_MAX;
	endfunction

	// both request ports are open only between transfers
	assign idle = (state_r == uad_pkg::UAD_ST_IDLE);
	assign fetching = (state_r == uad_pkg::UAD_ST_FETCH);
	assign sending = (state_r == uad_pkg::UAD_ST_SEND);

	// decoded against the setting in force before a set-interface of the same cycle
	assign req_map = entry_of(alt_r, desc_req_in);
	assign req_ok = req_map[4];
	assign req_entry = req_map[3:0];
	assign req_len = len_of(desc_req_in);
	assign req_take = desc_req_valid_in && idle;
	// a zero-length request loads the cursor but sends nothing
	assign req_load = req_take && req_ok;
	assign byte_take = sending && desc_byte_ready_in;

	// set-interface is taken only while idle
	assign setif_take = setif_valid_in && setif_ready_out;

	assign desc_req_ready_out = idle;
	// selection only changes between transfers
	assign setif_ready_out = idle;
	assign setif_stall_out = setif_stall_r;
	assign desc_stall_out = desc_stall_r;
	assign alt_setting_out = alt_r;
	assign desc_byte_valid_out = sending;
	// data and last flag both come from registers and change together
	assign desc_byte_out = '{data: rom_data, last: last_r};

	// registered read: a byte appears one cycle after the cursor moves
	uad_desc_rom u_rom (
		.sys_clk_in(sys_clk_in),
		.rstn_in(rstn_in),
		.entry_in(entry_r),
		.offset_in(offset_r),
		.rd_data_out(rom_data)
	);

	// alternate setting selected by set-interface
	always_ff @(posedge sys_clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
			alt_r <= uad_pkg::UAD_ALT_DEFAULT;
		else if (setif_take && alt_legal(setif_alt_in))
			alt_r <= setif_alt_in;
	end

	// a refused setting leaves the old one in force and answers with one stall cycle
	always_ff @(posedge sys_clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
			setif_stall_r <= 1'b0;
		else
			setif_stall_r <= setif_take && !alt_legal(setif_alt_in);
	end

	// unknown descriptor for the current setting answers with a stall pulse
	always_ff @(posedge sys_clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
			desc_stall_r <= 1'b0;
		else
			desc_stall_r <= req_take && !req_ok;
	end

	// every byte gets its own fetch cycle so the rom register matches the offset
	always_comb
	begin
		state_nxt = state_r;
		unique case (state_r)
			uad_pkg::UAD_ST_IDLE:
				if (req_load && req_len != 8'h00)
					state_nxt = uad_pkg::UAD_ST_FETCH;
			uad_pkg::UAD_ST_FETCH:
				state_nxt = uad_pkg::UAD_ST_SEND;
			uad_pkg::UAD_ST_SEND:
				if (byte_take)
					state_nxt = (remain_r == 8'h01) ? uad_pkg::UAD_ST_IDLE : uad_pkg::UAD_ST_FETCH;
			default:
				state_nxt = uad_pkg::UAD_ST_IDLE;
		endcase
	end

	// transfer state
	always_ff @(posedge sys_clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
			state_r <= uad_pkg::UAD_ST_IDLE;
		else
			state_r <= state_nxt;
	end

	// descriptor cursor: rom entry of the request in flight
	always_ff @(posedge sys_clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
			entry_r <= 4'h0;
		else if (req_load)
			entry_r <= req_entry;
	end

	// offset walks the descriptor in byte order; a cut request stops early
	always_ff @(posedge sys_clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
			offset_r <= 4'h0;
		else if (req_load)
			offset_r <= uad_pkg::UAD_OFS_LEN;
		else if (byte_take)
			offset_r <= offset_r + 4'h1;
	end

	// bytes still owed to the host, never above the descriptor length
	always_ff @(posedge sys_clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
			remain_r <= 8'h00;
		else if (req_load)
			remain_r <= req_len;
		else if (byte_take)
			remain_r <= remain_r - 8'h01;
	end

	// last-byte flag taken in the fetch cycle, beside the rom read
	always_ff @(posedge sys_clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
			last_r <= 1'b0;
		else if (fetching)
			last_r <= (remain_r == 8'h01);
	end
endmodule
`default_nettype wire

// ===== testbench/uad_asserts.sv
// timing and content checks on the descriptor server ports
`timescale 1ns/1ps
`default_nettype none
module uad_asserts (
	// clock and reset
	input wire logic sys_clk_in,
	input wire logic rstn_in,
	// set-interface
	input wire logic setif_valid_in,
	input wire logic [7:0] setif_alt_in,
	input wire logic setif_ready_out,
	input wire logic setif_stall_out,
	input wire logic [7:0] alt_setting_out,
	// get-descriptor
	input wire logic desc_req_valid_in,
	input wire uad_pkg::uad_req_type desc_req_in,
	input wire logic desc_req_ready_out,
	input wire logic desc_stall_out,
	// byte stream
	input wire logic desc_byte_valid_out,
	input wire uad_pkg::uad_byte_type desc_byte_out,
	input wire logic desc_byte_ready_in
);
	logic tk;
	logic st;
	logic acc;
	assign tk = desc_req_valid_in && desc_req_ready_out && desc_req_in.max_len != 16'h0000;
	assign st = setif_valid_in && setif_ready_out;
	assign acc = desc_byte_valid_out && desc_byte_ready_in;
	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (!rstn_in);
	ep_first_a: assert property (
		tk && desc_req_in.is_endpoint |=> desc_stall_out or
		##1 (desc_byte_valid_out && desc_byte_out.data == uad_pkg::UAD_EP_DESC_LEN))
		else $error("endpoint descriptor does not open with 07");
	if_first_a: assert property (
		tk && !desc_req_in.is_endpoint |=> desc_stall_out or
		##1 (desc_byte_valid_out && desc_byte_out.data == uad_pkg::UAD_IF_DESC_LEN))
		else $error("interface descriptor does not open with 09");
	alt0_stall_a: assert property (
		tk && alt_setting_out == uad_pkg::UAD_ALT_DEFAULT |=> desc_stall_out)
		else $error("request in setting 0 not stalled");
	alt_set_a: assert property (
		st && setif_alt_in <= uad_pkg::UAD_ALT_MAX |=>
		alt_setting_out == $past(setif_alt_in) && !setif_stall_out)
		else $error("setting not taken");
	alt_keep_a: assert property (
		st && setif_alt_in > uad_pkg::UAD_ALT_MAX |=>
		setif_stall_out && $stable(alt_setting_out))
		else $error("bad setting not refused");
	byte_hold_a: assert property (
		desc_byte_valid_out && !desc_byte_ready_in |=>
		desc_byte_valid_out && $stable(desc_byte_out))
		else $error("byte dropped while stalled");
	byte_gap_a: assert property (
		acc && !desc_byte_out.last |=> !desc_byte_valid_out ##1 desc_byte_valid_out)
		else $error("next byte not offered");
	end_idle_a: assert property (
		acc && desc_byte_out.last |=> desc_req_ready_out && !desc_byte_valid_out)
		else $error("no idle after last byte");
	busy_refuse_a: assert property (
		desc_byte_valid_out |-> !desc_req_ready_out && !setif_ready_out)
		else $error("request accepted while busy");
	cover property (st && setif_alt_in == 8'h02);
	cover property (acc && desc_byte_out.last);
	cover property (desc_stall_out);
endmodule
`default_nettype wire

// ===== testbench/uad_host_model.sv
// host side consumer of descriptor bytes, prompt or slow
`timescale 1ns/1ps
`default_nettype none
module uad_host_model (
	// clock
	input wire logic sys_clk_in,
	// byte stream
	input wire logic slow_in,
	input wire logic valid_in,
	input wire uad_pkg::uad_byte_type byte_in,
	output logic ready_out
);
	uad_pkg::uad_byte_type got [$];
	initial ready_out = 1'b1;
	always @(negedge sys_clk_in)
		ready_out <= slow_in ? ~ready_out : 1'b1;
	always @(posedge sys_clk_in)
		if (valid_in && ready_out)
			got.push_back(byte_in);
endmodule
`default_nettype wire

// ===== testbench/tb.sv
// self-checking bench for the descriptor server
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic sys_clk_in, rstn_in, setif_valid_in, setif_ready_out, setif_stall_out, slow;
	logic desc_req_valid_in, desc_req_ready_out, desc_stall_out;
	logic desc_byte_valid_out, desc_byte_ready_in;
	logic [7:0] setif_alt_in, alt_setting_out;
	uad_pkg::uad_req_type desc_req_in;
	uad_pkg::uad_byte_type desc_byte_out;
	int fails = 0;
	int comparisons = 0;
	logic [55:0] a1 [4] = '{56'h07050202000200, 56'h07050402000200, 56'h07058602000200,
		56'h07058802000200};
	logic [55:0] a2 [6] = '{56'h07050103400001, 56'h07058103400001, 56'h07050203000201,
		56'h07050402000200, 56'h07058603000201, 56'h07058802000200};
	uad_descriptor_server dut (.sys_clk_in, .rstn_in, .setif_valid_in, .setif_alt_in,
		.setif_ready_out, .setif_stall_out, .alt_setting_out, .desc_req_valid_in, .desc_req_in,
		.desc_req_ready_out, .desc_stall_out, .desc_byte_valid_out, .desc_byte_out,
		.desc_byte_ready_in);
	uad_host_model host (.sys_clk_in(sys_clk_in), .slow_in(slow), .valid_in(desc_byte_valid_out),
		.byte_in(desc_byte_out), .ready_out(desc_byte_ready_in));
	task chk(input string nm, input logic [15:0] x, input logic [15:0] y);
		comparisons++;
		if (y !== x)
		begin
			fails++;
			$display("CHECK FAILED %s expected %h seen %h", nm, x, y);
		end
	endtask
	task setif(input logic [7:0] a, input logic [7:0] ea, input logic es);
		@(negedge sys_clk_in);
		setif_valid_in = 1'b1;
		setif_alt_in = a;
		while (!setif_ready_out)
			@(negedge sys_clk_in);
		@(negedge sys_clk_in);
		setif_valid_in = 1'b0;
		chk("setting", {7'h0, ea, es}, {7'h0, alt_setting_out, setif_stall_out});
	endtask
	task get(input logic ep, input logic [2:0] ix, input logic [15:0] ml, input logic [71:0] e,
		input int n, input logic st);
		@(negedge sys_clk_in);
		host.got.delete();
		desc_req_valid_in = 1'b1;
		desc_req_in = '{is_endpoint: ep, ep_index: ix, max_len: ml};
		while (!desc_req_ready_out)
			@(negedge sys_clk_in);
		@(negedge sys_clk_in);
		desc_req_valid_in = 1'b0;
		chk("stall", {15'h0, st}, {15'h0, desc_stall_out});
		while (!desc_req_ready_out)
			@(negedge sys_clk_in);
		chk("count", n[15:0], 16'(host.got.size()));
		for (int i = 0; i < n; i++)
			chk("byte", {7'h0, e[71-8*i -: 8], i == n - 1}, {7'h0, host.got[i]});
	endtask
	task final_report;
		$display("comparisons %0d mismatches %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	initial
	begin
		sys_clk_in = 1'b0;
		forever #20 sys_clk_in = ~sys_clk_in;
	end
	initial
	begin
		#200000;
		fails++;
		final_report;
	end
	task test_reset;
		repeat (20) @(negedge sys_clk_in);
		chk("reset", 16'h0060, {alt_setting_out, 1'b0, setif_ready_out, desc_req_ready_out,
			desc_byte_valid_out, setif_stall_out, desc_stall_out, 2'b00});
		rstn_in = 1'b1;
		$display("reset test done");
	endtask
	task test_alt0;
		get(1'b1, 3'd0, 16'd7, 72'h0, 0, 1'b1);
		$display("setting zero test done");
	endtask
	task test_bulk;
		slow = 1'b1;
		setif(8'h01, 8'h01, 1'b0);
		for (int i = 0; i < 4; i++)
			get(1'b1, i[2:0], 16'd7, {a1[i], 16'h0}, 7, 1'b0);
		get(1'b0, 3'd0, 16'd9, 72'h0, 0, 1'b1);
		get(1'b1, 3'd4, 16'd7, 72'h0, 0, 1'b1);
		$display("bulk setting test done");
	endtask
	task test_mixed;
		slow = 1'b0;
		setif(8'h02, 8'h02, 1'b0);
		get(1'b0, 3'd0, 16'd9, 72'h0904000206ffffff00, 9, 1'b0);
		for (int i = 0; i < 6; i++)
			get(1'b1, i[2:0], 16'd7, {a2[i], 16'h0}, 7, 1'b0);
		get(1'b1, 3'd2, 16'd3, {a2[2], 16'h0}, 3, 1'b0);
		get(1'b1, 3'd0, 16'd0, 72'h0, 0, 1'b0);
		get(1'b1, 3'd6, 16'd7, 72'h0, 0, 1'b1);
		$display("mixed setting test done");
	endtask
	task test_refuse;
		setif(8'h05, 8'h02, 1'b1);
		setif(8'h03, 8'h03, 1'b0);
		get(1'b1, 3'd0, 16'd7, 72'h0, 0, 1'b1);
		$display("refusal test done");
	endtask
	initial
	begin
		rstn_in = 1'b0;
		setif_valid_in = 1'b0;
		setif_alt_in = 8'h00;
		desc_req_valid_in = 1'b0;
		desc_req_in = '0;
		slow = 1'b0;
		test_reset;
		test_alt0;
		test_bulk;
		test_mixed;
		test_refuse;
		final_report;
	end
endmodule
bind uad_descriptor_server uad_asserts chk_i (.sys_clk_in, .rstn_in, .setif_valid_in,
	.setif_alt_in, .setif_ready_out, .setif_stall_out, .alt_setting_out, .desc_req_valid_in,
	.desc_req_in, .desc_req_ready_out, .desc_stall_out, .desc_byte_valid_out, .desc_byte_out,
	.desc_byte_ready_in);
`default_nettype wire
